// File: bsq_pkg.sv
// bsq_pkg: constants, register map and carrier types of the buck startup sequencer.
// assumes a 50 MHz core clock; all timing counts below are derived from it.
package bsq_pkg;

    // ************************************************************
    // clock and switching timing
    // ************************************************************
    localparam int CLK_NS = 20;                           // core clock period, ns
    localparam int NOM_KHZ = 400;                         // nominal switching rate
    localparam int NOM_CYC = 1_000_000 / (NOM_KHZ * CLK_NS);   // 125 clocks
    localparam int LEADER_PCT = 15;                       // leader speed-up, percent
    localparam int LEADER_CYC = (NOM_CYC * 100) / (100 + LEADER_PCT);
    localparam int FOL_MAX_PCT = 60;                      // fastest clock a follower takes
    localparam int FOL_MIN_CYC = (NOM_CYC * 100) / (100 + FOL_MAX_PCT);
    localparam int FOL_MAX_CYC = (NOM_CYC * 100 + 100 + LEADER_PCT - 1) / (100 + LEADER_PCT);
    localparam int NOV_NS = 85;                           // gate non-overlap, ns
    localparam int NOV_CYC = (NOV_NS + CLK_NS - 1) / CLK_NS;

    // ************************************************************
    // sequence timing
    // ************************************************************
    localparam int ROLE_US = 50;                          // role decision period
    localparam int ROLE_CYC = (ROLE_US * 1000) / CLK_NS;
    localparam int WATCH_US = 40;                         // least sync watch time
    localparam int WATCH_CYC = (WATCH_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int PRESTART_US = 400;                     // boost charge and limit set
    localparam int PRESTART_CYC = (PRESTART_US * 1000) / CLK_NS;
    localparam int SS_STEPS = 32;                         // reference steps
    localparam int SS_TOTAL_US = 5120;                    // whole soft-start
    localparam int STEP_CYC = (SS_TOTAL_US * 1000) / (SS_STEPS * CLK_NS);
    localparam int SYNC_EDGES = 2;                        // edges that prove a clock

    // ************************************************************
    // register map (byte addresses) and reset values
    // ************************************************************
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] STATUS_OFF = 8'h04;
    localparam logic [7:0] FAULT_OFF = 8'h08;
    localparam int CTRL_FORCE_OFF_BIT = 0;
    localparam int FAULT_LOW_BIT = 0;
    localparam int FAULT_HIGH_BIT = 1;
    localparam logic CTRL_FORCE_OFF_RST = 1'b0;
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_ROLE_VALID_BIT = 9;
    localparam int STAT_LEADER_BIT = 10;
    localparam int STAT_STEP_LSB = 11;
    localparam int STAT_OK_BIT = 17;

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [8:0] {
        ST_LOCKOUT = 9'b0_0000_0001,
        ST_ROLE = 9'b0_0000_0010,
        ST_STANDBY = 9'b0_0000_0100,
        ST_PRESTART = 9'b0_0000_1000,
        ST_SOFTSTART = 9'b0_0001_0000,
        ST_RUN = 9'b0_0010_0000,
        ST_SOFTSTOP = 9'b0_0100_0000,
        ST_LAST = 9'b0_1000_0000,
        ST_LATCHED = 9'b1_0000_0000
    } bsq_state_type;

    // feedback window comparators, each high when feedback is above its level
    typedef struct packed {
        logic above_1p00;
        logic above_0p88;
        logic above_0p72;
        logic above_0p60;
    } bsq_fb_cmp_type;

    typedef struct packed {
        logic hs_gate;
        logic ls_gate;
        logic hs_sense_en;
    } bsq_gate_type;

endpackage : bsq_pkg

// File: bsq_sequencer.sv
// bsq_sequencer: startup, role, soft-start/stop, gates and feedback window, APB registers.
// assumes sys_rst is power-on reset and every pin input is asynchronous to core_clk.
// Overview of operation
// R1: 400 kHz cycle from core clock when not synchronised
// R2: lockout or reset holds logic and gates off
// R3: after lockout, 50 us role decision
// R4: then standby until turn-on
// R5: turn-on starts 400 us prestart delay
// R6: error amplifier clamped below ramp valley in prestart
// R7: soft-start to 0.8 V in 32 steps, 5.12 ms
// R8: turn-on low steps reference down to zero
// R9: soft-stop ends with one half-width high-side pulse
// R10: turn-on reversal during a ramp reverses from current step
// R11: 1.25 V on sync; leader if current above trip
// R12: leader runs 15 percent fast
// R13: leader sync clock 180 degrees from high side
// R14: sync edges within 40 us mean follower
// R15: role kept until power cycled
// R16: follower locks to clocks 15 to 60 percent fast
// R17: late external clock idles sync high
// R18: window ignored in soft-start, output ok low
// R19: below 0.6 V after soft-start: undervoltage, restart
// R20: output ok only between 0.72 and 0.88 V
// R21: above 1.0 V latches off until power cycled
// R22: fixed symmetric gate non-overlap
// R23: high-side sensing only while high side on
// R24: each reference step about 160 us
// R25: delays counted on core clock, cleared by reset
`timescale 1ns/1ps
module bsq_sequencer #(
    parameter int PRESTART_CYC = bsq_pkg::PRESTART_CYC,
    parameter int STEP_CYC = bsq_pkg::STEP_CYC
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic supply_low_lockout,
    input wire logic turn_on,
    input wire logic leader_select_current,
    input wire logic pwm_off,
    input wire bsq_pkg::bsq_fb_cmp_type feedback_node,
    input wire logic sync_in,
    output logic sync_out,
    output logic sync_oe,
    output logic sync_bias_en,
    output logic error_amplifier_clamp,
    output logic startup_prep,
    output logic [5:0] ref_step,
    output logic output_ok_flag,
    output bsq_pkg::bsq_gate_type gate_drive,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);

    // ************************************************************
    // input synchronisers
    // ************************************************************
    localparam int NIN = 9;
    logic [NIN-1:0] in_meta_r;
    logic [NIN-1:0] in_sync_r;
    logic sync_prev_r;
    logic lockout_s, en_pin_s, sync_s, leader_cur_s, pwm_off_s;
    bsq_pkg::bsq_fb_cmp_type fb_s;
    // two flops per pin, reset to idle levels: no false sync edge or lockout gap
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            in_meta_r <= 9'h140;
            in_sync_r <= 9'h140;
        end else begin
            in_meta_r <= {supply_low_lockout, turn_on, sync_in, leader_select_current,
                          pwm_off, feedback_node};
            in_sync_r <= in_meta_r;
        end
    end
    assign lockout_s = in_sync_r[8];
    assign en_pin_s = in_sync_r[7];
    assign sync_s = in_sync_r[6];
    assign leader_cur_s = in_sync_r[5];
    assign pwm_off_s = in_sync_r[4];
    assign fb_s = in_sync_r[3:0];

    // ************************************************************
    // register port
    // ************************************************************
    logic force_off_r;
    logic fault_low_r, fault_high_r;
    bsq_pkg::bsq_state_type state_r;
    logic role_valid_r, leader_r, ok_r;
    logic [5:0] step_r;
    logic wr_en, uv_event, ov_event;
    function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction : addr_hit
    // zero wait states
    assign pready = 1'b1;
    assign wr_en = psel && penable && pwrite;
    assign pslverr = psel && penable && !(addr_hit(paddr, bsq_pkg::CTRL_OFF)
        || addr_hit(paddr, bsq_pkg::STATUS_OFF) || addr_hit(paddr, bsq_pkg::FAULT_OFF));

    // control register; force-off acts as turn-on low
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            force_off_r <= bsq_pkg::CTRL_FORCE_OFF_RST;
        end else if (wr_en && addr_hit(paddr, bsq_pkg::CTRL_OFF)) begin
            force_off_r <= pwdata[bsq_pkg::CTRL_FORCE_OFF_BIT];
        end
    end

    // sticky fault flags, write one to clear; a new event beats the clear
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            fault_low_r <= 1'b0;
            fault_high_r <= 1'b0;
        end else begin
            if (uv_event) begin
                fault_low_r <= 1'b1; // R19
            end else if (wr_en && addr_hit(paddr, bsq_pkg::FAULT_OFF)
                         && pwdata[bsq_pkg::FAULT_LOW_BIT]) begin
                fault_low_r <= 1'b0;
            end
            if (ov_event) begin
                fault_high_r <= 1'b1; // R21
            end else if (wr_en && addr_hit(paddr, bsq_pkg::FAULT_OFF)
                         && pwdata[bsq_pkg::FAULT_HIGH_BIT]) begin
                fault_high_r <= 1'b0;
            end
        end
    end

    // read data captured in setup, so it stands as a flop in access
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable) begin
            prdata <= 32'h0000_0000;
            if (addr_hit(paddr, bsq_pkg::CTRL_OFF)) begin
                prdata[bsq_pkg::CTRL_FORCE_OFF_BIT] <= force_off_r;
            end else if (addr_hit(paddr, bsq_pkg::STATUS_OFF)) begin
                prdata[bsq_pkg::STAT_STATE_LSB +: 9] <= state_r;
                prdata[bsq_pkg::STAT_ROLE_VALID_BIT] <= role_valid_r;
                prdata[bsq_pkg::STAT_LEADER_BIT] <= leader_r;
                prdata[bsq_pkg::STAT_STEP_LSB +: 6] <= step_r;
                prdata[bsq_pkg::STAT_OK_BIT] <= ok_r;
            end else if (addr_hit(paddr, bsq_pkg::FAULT_OFF)) begin
                prdata[bsq_pkg::FAULT_LOW_BIT] <= fault_low_r;
                prdata[bsq_pkg::FAULT_HIGH_BIT] <= fault_high_r;
            end
        end
    end

    // ************************************************************
    // switching cycle and sync pin
    // ************************************************************
    logic [7:0] per_cnt_r;
    logic [7:0] per_lim;
    logic sync_rise, lock_edge, cyc_start;
    assign sync_rise = sync_s && !sync_prev_r;
    assign per_lim = leader_r ? 8'(bsq_pkg::LEADER_CYC) : 8'(bsq_pkg::NOM_CYC); // R12
    // follower restarts on an edge spaced within the lock range
    assign lock_edge = role_valid_r && !leader_r && sync_rise
        && per_cnt_r >= 8'(bsq_pkg::FOL_MIN_CYC - 1)
        && per_cnt_r <= 8'(bsq_pkg::FOL_MAX_CYC - 1); // R16
    assign cyc_start = lock_edge || per_cnt_r == per_lim - 8'd1;

    // period counter; wraps at its own limit when no valid clock arrives
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            per_cnt_r <= 8'd0;
            sync_prev_r <= 1'b1;
        end else begin
            sync_prev_r <= sync_s;
            per_cnt_r <= cyc_start ? 8'd0 : per_cnt_r + 8'd1; // R1
        end
    end
    // leader clock high in the second half, opposite the high side
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sync_out <= 1'b0;
            sync_oe <= 1'b0;
        end else begin
            sync_oe <= role_valid_r && leader_r; // R13
            sync_out <= role_valid_r && leader_r && per_cnt_r >= (per_lim >> 1); // R13
        end
    end

    // ************************************************************
    // sequencer
    // ************************************************************
    logic [15:0] tmr_r;
    logic [2:0] edge_cnt_r;
    logic enable, last_done;
    // a late outside clock idles high, so it shows no edges
    assign enable = en_pin_s && !force_off_r; // R17
    assign uv_event = state_r == bsq_pkg::ST_RUN && !fb_s.above_1p00 && !fb_s.above_0p60;
    assign ov_event = state_r == bsq_pkg::ST_RUN && fb_s.above_1p00;

    // main state machine, timer, reference step and role
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_r <= bsq_pkg::ST_LOCKOUT; // R25
            tmr_r <= 16'd0; // R25
            edge_cnt_r <= 3'd0;
            step_r <= 6'd0;
            role_valid_r <= 1'b0;
            leader_r <= 1'b0;
        end else if (lockout_s && state_r != bsq_pkg::ST_LATCHED) begin
            state_r <= bsq_pkg::ST_LOCKOUT; // R2
            tmr_r <= 16'd0;
            step_r <= 6'd0;
        end else begin
            tmr_r <= tmr_r + 16'd1;
            unique case (state_r)
                bsq_pkg::ST_LOCKOUT: begin
                    tmr_r <= 16'd0;
                    edge_cnt_r <= 3'd0;
                    // the role survives a brownout; only power-on reset clears it
                    state_r <= role_valid_r ? bsq_pkg::ST_STANDBY : bsq_pkg::ST_ROLE; // R15
                end
                bsq_pkg::ST_ROLE: begin
                    if (sync_rise && tmr_r < 16'(bsq_pkg::WATCH_CYC)
                        && edge_cnt_r != 3'(bsq_pkg::SYNC_EDGES)) begin
                        edge_cnt_r <= edge_cnt_r + 3'd1; // R14
                    end
                    if (tmr_r == 16'(bsq_pkg::ROLE_CYC - 1)) begin
                        role_valid_r <= 1'b1; // R3
                        // edges seen win over the current test
                        leader_r <= edge_cnt_r != 3'(bsq_pkg::SYNC_EDGES)
                            && leader_cur_s; // R11
                        state_r <= bsq_pkg::ST_STANDBY;
                    end
                end
                bsq_pkg::ST_STANDBY: begin
                    tmr_r <= 16'd0;
                    step_r <= 6'd0;
                    if (enable) begin
                        state_r <= bsq_pkg::ST_PRESTART; // R4
                    end
                end
                bsq_pkg::ST_PRESTART: begin
                    if (!enable) begin
                        state_r <= bsq_pkg::ST_STANDBY;
                    end else if (tmr_r == 16'(PRESTART_CYC - 1)) begin
                        tmr_r <= 16'd0;
                        state_r <= bsq_pkg::ST_SOFTSTART; // R5
                    end
                end
                bsq_pkg::ST_SOFTSTART: begin
                    if (!enable) begin
                        state_r <= bsq_pkg::ST_SOFTSTOP; // R10
                    end else if (tmr_r == 16'(STEP_CYC - 1)) begin
                        tmr_r <= 16'd0; // R24
                        step_r <= step_r + 6'd1; // R7
                        if (step_r == 6'(bsq_pkg::SS_STEPS - 1)) begin
                            state_r <= bsq_pkg::ST_RUN;
                        end
                    end
                end
                bsq_pkg::ST_RUN: begin
                    tmr_r <= 16'd0;
                    if (ov_event) begin
                        state_r <= bsq_pkg::ST_LATCHED; // R21
                    end else if (uv_event) begin
                        step_r <= 6'd0; // R19
                        state_r <= bsq_pkg::ST_PRESTART;
                    end else if (!enable) begin
                        state_r <= bsq_pkg::ST_SOFTSTOP; // R8
                    end
                end
                bsq_pkg::ST_SOFTSTOP: begin
                    if (enable) begin
                        state_r <= bsq_pkg::ST_SOFTSTART; // R10
                    end else if (tmr_r == 16'(STEP_CYC - 1)) begin
                        tmr_r <= 16'd0; // R24
                        step_r <= step_r - 6'd1; // R8
                        if (step_r == 6'd1) begin
                            state_r <= bsq_pkg::ST_LAST;
                        end
                    end
                end
                bsq_pkg::ST_LAST: begin
                    if (last_done) begin
                        state_r <= bsq_pkg::ST_STANDBY; // R9
                    end
                end
                bsq_pkg::ST_LATCHED: begin
                    tmr_r <= 16'd0; // R21
                end
                default: begin
                    state_r <= bsq_pkg::ST_LOCKOUT;
                end
            endcase
        end
    end

    // ************************************************************
    // high-side request, last pulse and non-overlap
    // ************************************************************
    logic switching, hs_req_r, drv_hs_r;
    logic [7:0] on_cnt_r, prev_on_r;
    logic last_armed_r, last_fired_r;
    logic [2:0] dead_r;
    assign switching = state_r == bsq_pkg::ST_SOFTSTART || state_r == bsq_pkg::ST_RUN
        || state_r == bsq_pkg::ST_SOFTSTOP;
    assign last_done = last_fired_r && !hs_req_r && dead_r == 3'd0;

    // pwm request: on at cycle start, off at the pwm comparator or 2 * NOV_CYC + 1 clocks before the period end
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            hs_req_r <= 1'b0;
            on_cnt_r <= 8'd0;
            prev_on_r <= 8'd0;
            last_armed_r <= 1'b0;
            last_fired_r <= 1'b0;
        end else if (state_r == bsq_pkg::ST_LAST) begin
            // one pulse of half the prior width, timed by the same counter
            if (!last_armed_r && cyc_start) begin
                last_armed_r <= 1'b1;
                hs_req_r <= prev_on_r > 8'd1; // R9
                on_cnt_r <= 8'd1;
            end else if (hs_req_r) begin
                on_cnt_r <= on_cnt_r + 8'd1;
                if (on_cnt_r >= (prev_on_r >> 1)) begin
                    hs_req_r <= 1'b0; // R9
                    last_fired_r <= 1'b1;
                end
            end else if (last_armed_r) begin
                last_fired_r <= 1'b1;
            end
        end else begin
            last_armed_r <= 1'b0;
            last_fired_r <= 1'b0;
            if (!switching) begin
                hs_req_r <= 1'b0;
                on_cnt_r <= 8'd0;
            end else if (cyc_start) begin
                prev_on_r <= on_cnt_r;
                on_cnt_r <= 8'd1;
                hs_req_r <= 1'b1;
            end else if (hs_req_r) begin
                on_cnt_r <= on_cnt_r + 8'd1;
                // leave room for two dead times before the next start
                if (pwm_off_s || per_cnt_r >= per_lim - 8'(2 * bsq_pkg::NOV_CYC + 1)) begin
                    hs_req_r <= 1'b0;
                end
            end
        end
    end

    // both switches off a fixed count on every change
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            drv_hs_r <= 1'b0;
            dead_r <= 3'd0;
            gate_drive <= '0;
        end else begin
            if (hs_req_r != drv_hs_r) begin
                drv_hs_r <= hs_req_r;
                dead_r <= 3'(bsq_pkg::NOV_CYC); // R22
            end else if (dead_r != 3'd0) begin
                dead_r <= dead_r - 3'd1; // R22
            end
            gate_drive.hs_gate <= drv_hs_r && dead_r == 3'd0 && hs_req_r == drv_hs_r;
            gate_drive.ls_gate <= (switching || state_r == bsq_pkg::ST_LAST)
                && !last_fired_r && !drv_hs_r && dead_r == 3'd0 && !hs_req_r; // R22
            gate_drive.hs_sense_en <= drv_hs_r && dead_r == 3'd0
                && hs_req_r == drv_hs_r; // R23
        end
    end

    // ************************************************************
    // status outputs
    // ************************************************************
    // output ok follows the window only once soft-start has finished
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ok_r <= 1'b0;
            output_ok_flag <= 1'b0;
            sync_bias_en <= 1'b0;
            error_amplifier_clamp <= 1'b0;
            startup_prep <= 1'b0;
            ref_step <= 6'd0;
        end else begin
            ok_r <= state_r == bsq_pkg::ST_RUN && fb_s.above_0p72
                && !fb_s.above_0p88 && !fb_s.above_1p00; // R20
            output_ok_flag <= ok_r; // R18
            sync_bias_en <= state_r == bsq_pkg::ST_ROLE
                && tmr_r >= 16'(bsq_pkg::WATCH_CYC); // R11
            error_amplifier_clamp <= state_r == bsq_pkg::ST_PRESTART; // R6
            startup_prep <= state_r == bsq_pkg::ST_PRESTART; // R5
            ref_step <= step_r; // R7
        end
    end
endmodule : bsq_sequencer

// File: bsq_sequencer_properties.sv
// bsq_sequencer_properties: port-level checks of the buck sequencer.
// assumes feedback levels held steady for many cycles.
`timescale 1ns/1ps
module bsq_chk (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic supply_low_lockout,
    input wire bsq_pkg::bsq_fb_cmp_type feedback_node,
    input wire logic [5:0] ref_step,
    input wire logic output_ok_flag,
    input wire bsq_pkg::bsq_gate_type gate_drive
);
    // one clock domain
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    a_lockout_gates: assert property (supply_low_lockout [*8] |=> gate_drive == 3'h0)
        else $error("gates active in lockout");
    a_no_overlap: assert property (!(gate_drive.hs_gate && gate_drive.ls_gate))
        else $error("gates overlap");
    a_hs_dead: assert property ($fell(gate_drive.hs_gate) |-> !gate_drive.ls_gate [*5])
        else $error("short dead time");
    a_sense_follows: assert property (gate_drive.hs_sense_en == gate_drive.hs_gate)
        else $error("sense outside high-side on time");
    a_ok_at_top: assert property (output_ok_flag |-> ref_step == 6'h20)
        else $error("output ok during ramp");
    a_ok_window: assert property ((!feedback_node.above_0p72 || feedback_node.above_0p88)
        [*8] |=> !output_ok_flag) else $error("output ok outside window");
    a_step_up_one: assert property (ref_step > $past(ref_step)
        |-> ref_step == $past(ref_step) + 6'h1) else $error("step jumped");
    a_step_hold: assert property ($changed(ref_step) && ref_step != 6'h0
        |=> $stable(ref_step) [*8]) else $error("step too short");
    a_over_latch: assert property ((feedback_node.above_1p00 && ref_step == 6'h20) [*8]
        |=> !gate_drive.hs_gate [*8]) else $error("no latch on overvoltage");
    c_run: cover property (output_ok_flag);
    c_hs: cover property ($rose(gate_drive.hs_gate));
    c_lock: cover property (supply_low_lockout [*8]);
endmodule : bsq_chk
bind bsq_sequencer bsq_chk i_chk (.*);

// File: bsq_sync_src.sv
// bsq_sync_src: outside clock source on the sync pin.
// assumes a pull-up, so a released line reads high.
`timescale 1ns/1ps
module bsq_sync_src #(
    parameter int HALF_NS = 80
) (
    input wire logic run,
    input wire logic sync_out,
    input wire logic sync_oe,
    output logic sync_pin
);
    logic clk_src;
    // clock only while run, idle high
    initial begin
        clk_src = 1'b1;
        forever begin
            #(HALF_NS);
            clk_src = run ? ~clk_src : 1'b1;
        end
    end
    // device drive wins, else source or pull-up
    assign sync_pin = sync_oe ? sync_out : clk_src;
endmodule : bsq_sync_src

// File: buck_startup_sync_fault_sequencer_test.sv
// buck_startup_sync_fault_sequencer_test: pin and APB sequences.
// assumes short prestart and step counts; bsq_chk bound to the design.
`timescale 1ns/1ps
module buck_startup_sync_fault_sequencer_test;
    logic core_clk, sys_rst, supply_low_lockout, turn_on, leader_select_current, pwm_off;
    logic sync_in, sync_out, sync_oe, bias, clamp, prep, output_ok_flag, run_src, e;
    logic psel, penable, pwrite, pready, pslverr;
    logic [5:0] ref_step;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    bsq_pkg::bsq_fb_cmp_type feedback_node;
    bsq_pkg::bsq_gate_type gate_drive;
    int err_total, checks;
    bsq_sequencer #(.PRESTART_CYC(40), .STEP_CYC(20)) i_dut (.core_clk, .sys_rst,
        .supply_low_lockout, .turn_on, .leader_select_current, .pwm_off, .feedback_node,
        .sync_in, .sync_out, .sync_oe, .sync_bias_en(bias), .error_amplifier_clamp(clamp),
        .startup_prep(prep), .ref_step, .output_ok_flag, .gate_drive, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
    bsq_sync_src i_src (.run(run_src), .sync_out(sync_out), .sync_oe(sync_oe),
        .sync_pin(sync_in));
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    // ********************************
    // access and compare tasks
    // ********************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    // answer taken at the rising edge that sees pready, then released
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask : apb
    task automatic wait_st(input logic [8:0] s);
        int n = 0;
        do begin
            apb(1'b0, bsq_pkg::STATUS_OFF, 32'h0);
            n++;
        end while (q[8:0] !== s && n < 3000);
        chk(q[8:0], s);
    endtask : wait_st
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : tally_and_finish
    // watchdog: the run needs about 8k cycles
    initial begin
        #1_500_000;
        err_total++;
        tally_and_finish();
    end
    initial begin
        sys_rst = 1'b1;
        supply_low_lockout = 1'b1;
        turn_on = 1'b0;
        leader_select_current = 1'b1;
        pwm_off = 1'b0;
        feedback_node = 4'h0;
        {psel, penable, pwrite, paddr, pwdata, run_src} = '0;
        err_total = 0;
        checks = 0;
        repeat (16) @(posedge core_clk);
        sys_rst <= 1'b0;
        repeat (20) @(posedge core_clk);
        chk(gate_drive, 3'h0);
        wait_st(bsq_pkg::ST_LOCKOUT);
        supply_low_lockout <= 1'b0;
        wait_st(bsq_pkg::ST_STANDBY);
        chk({q[10:9], sync_oe}, 3'h7);
        @(posedge sync_out);
        repeat (54) @(posedge core_clk);
        chk(sync_out, 1'b1);
        @(posedge core_clk);
        chk(sync_out, 1'b0);
        apb(1'b1, bsq_pkg::CTRL_OFF, 32'h1);
        apb(1'b0, bsq_pkg::CTRL_OFF, 32'h0);
        chk(q, 32'h1);
        apb(1'b1, bsq_pkg::CTRL_OFF, 32'h0);
        apb(1'b0, 8'h0C, 32'h0);
        chk(e, 1'b1);
        $display("leader test done");
        feedback_node <= 4'h3;
        turn_on <= 1'b1;
        wait_st(bsq_pkg::ST_PRESTART);
        chk({clamp, prep, output_ok_flag}, 3'h6);
        wait_st(bsq_pkg::ST_RUN);
        chk(ref_step, 6'h20);
        repeat (8) @(posedge core_clk);
        chk(output_ok_flag, 1'b1);
        turn_on <= 1'b0;
        wait_st(bsq_pkg::ST_SOFTSTOP);
        repeat (60) @(posedge core_clk);
        turn_on <= 1'b1;
        wait_st(bsq_pkg::ST_SOFTSTART);
        chk(ref_step inside {[6'h10:6'h1f]}, 1'b1);
        $display("ramp test done");
        wait_st(bsq_pkg::ST_RUN);
        feedback_node <= 4'h0;
        wait_st(bsq_pkg::ST_PRESTART);
        feedback_node <= 4'h3;
        apb(1'b0, bsq_pkg::FAULT_OFF, 32'h0);
        chk(q, 32'h1);
        apb(1'b1, bsq_pkg::FAULT_OFF, 32'h1);
        apb(1'b0, bsq_pkg::FAULT_OFF, 32'h0);
        chk(q, 32'h0);
        wait_st(bsq_pkg::ST_RUN);
        turn_on <= 1'b0;
        wait_st(bsq_pkg::ST_STANDBY);
        chk(ref_step, 6'h0);
        $display("restart test done");
        turn_on <= 1'b1;
        wait_st(bsq_pkg::ST_RUN);
        feedback_node <= 4'hf;
        wait_st(bsq_pkg::ST_LATCHED);
        turn_on <= 1'b0;
        repeat (40) @(posedge core_clk);
        apb(1'b0, bsq_pkg::FAULT_OFF, 32'h0);
        chk({q[1], gate_drive, output_ok_flag}, 5'h10);
        $display("latch test done");
        run_src <= 1'b1;
        sys_rst <= 1'b1;
        repeat (16) @(posedge core_clk);
        sys_rst <= 1'b0;
        repeat (2200) @(posedge core_clk);
        chk(bias, 1'b1);
        wait_st(bsq_pkg::ST_STANDBY);
        chk({q[10:9], sync_oe, bias}, 4'h4);
        supply_low_lockout <= 1'b1;
        wait_st(bsq_pkg::ST_LOCKOUT);
        supply_low_lockout <= 1'b0;
        wait_st(bsq_pkg::ST_STANDBY);
        chk(q[10:9], 2'h1);
        $display("follower test done");
        tally_and_finish();
    end
endmodule : buck_startup_sync_fault_sequencer_test
